// >>> rtl/eag_defines.svh
`ifndef EAG_DEFINES_SVH
`define EAG_DEFINES_SVH
`define EAG_SIZE_BYTE   2'h0
`define EAG_SIZE_WORD   2'h1
`define EAG_SIZE_LONG   2'h2
`define EAG_SIZE_QUAD   2'h3
`define EAG_DSZ_NONE    2'h0
`define EAG_DSZ_BYTE    2'h1
`define EAG_DSZ_WORD    2'h2
`define EAG_DSZ_LONG    2'h3
`define EAG_BF_MIN      6'h01
`define EAG_BF_MAX      6'h20
`define EAG_MODE_COUNT  5'h12
`define EAG_SP_SEL      3'h7
`endif

// >>> rtl/eag_pkg.sv
package eag_pkg;
    typedef enum logic [4:0] {
        EAG_DREG_DIRECT, EAG_AREG_DIRECT, EAG_AREG_IND, EAG_AREG_POSTINC,
        EAG_AREG_PREDEC, EAG_AREG_DISP, EAG_AREG_IDX8, EAG_AREG_IDXBD,
        EAG_MEM_POSTIDX, EAG_MEM_PREIDX, EAG_PC_DISP, EAG_PC_IDX8,
        EAG_PC_IDXBD, EAG_PC_MEM_POSTIDX, EAG_PC_MEM_PREIDX, EAG_ABS_SHORT,
        EAG_ABS_LONG, EAG_IMMEDIATE
    } eag_mode_type;
    typedef enum logic [2:0] {
        EAG_OP_BYTE, EAG_OP_WORD, EAG_OP_LONG, EAG_OP_QUAD,
        EAG_OP_BITFIELD, EAG_OP_BCD_PACKED, EAG_OP_BCD_UNPACKED
    } eag_optype_type;
endpackage : eag_pkg

// >>> rtl/eag_ext.sv
`timescale 1ns/1ps
`default_nettype none
`include "eag_defines.svh"
module eag_ext (
    input  wire logic [31:0] raw,
    input  wire logic [1:0]  dsz,
    output logic [31:0]      value
);
    // sign extend a displacement or immediate of byte, word or long size
    always_comb begin
        unique case (dsz)
            `EAG_DSZ_NONE: value = 32'h0000_0000;
            `EAG_DSZ_BYTE: value = {{24{raw[7]}}, raw[7:0]};
            `EAG_DSZ_WORD: value = {{16{raw[15]}}, raw[15:0]};
            `EAG_DSZ_LONG: value = raw;
        endcase
    end
endmodule : eag_ext
`default_nettype wire

// >>> rtl/eag_top.sv
// Functional notes
// (RULE1) bit fields of one to thirty-two bits
// (RULE2) bcd digits packed two or one per byte
// (RULE3) eighteen addressing modes in nine groups
// (RULE4) indirect with postinc, predec, offset, index
// (RULE5) signed byte or word displacement, sign-extended
// (RULE6) any register indexes, word or long
// (RULE7) index scaled by one, two, four, eight
// (RULE8) optional signed base displacement, selectable size
// (RULE9) outer displacement added after pointer fetch
// (RULE10) postindexed and preindexed memory indirect variants
// (RULE11) fetch long word pointer from intermediate address
// (RULE12) pc relative with displacement and index
// (RULE13) short indexed mode for address and pc
// (RULE14) immediates of eight, sixteen, thirty-two bits
// (RULE15) absolute short or long address
// (RULE16) eight data and eight address registers
// (RULE17) byte, word, long operand sizes
// (RULE18) integer operands up to sixty-four bits
// (RULE19) base adjusted by size, post or pre
`timescale 1ns/1ps
`default_nettype none
`include "eag_defines.svh"
module eag_top (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  start,
    input  wire eag_pkg::eag_mode_type mode,
    input  wire eag_pkg::eag_optype_type op_type,
    input  wire logic [5:0]            bf_width,
    input  wire logic [2:0]            data_reg_sel,
    input  wire logic [2:0]            addr_reg_sel,
    input  wire logic [3:0]            index_reg_sel,
    input  wire logic                  index_long,
    input  wire logic [1:0]            index_scale,
    input  wire logic                  index_suppress,
    input  wire logic                  base_suppress,
    input  wire logic [31:0]           base_disp,
    input  wire logic [1:0]            base_disp_size,
    input  wire logic [31:0]           outer_disp,
    input  wire logic [1:0]            outer_disp_size,
    input  wire logic [31:0]           ext_word,
    input  wire logic [31:0]           pc_value,
    input  wire logic [31:0]           reg_rdata,
    input  wire logic [31:0]           index_rdata,
    input  wire logic                  ptr_ack,
    input  wire logic [31:0]           ptr_data,
    input  wire logic                  access_done,
    output logic [31:0]                ea,
    output logic [31:0]                imm_value,
    output logic                       ea_valid,
    output logic                       is_imm,
    output logic                       is_reg,
    output logic                       reg_is_addr,
    output logic [2:0]                 reg_num,
    output logic [3:0]                 op_bytes,
    output logic [5:0]                 field_bits,
    output logic                       bad_operand,
    output logic                       ptr_req,
    output logic [31:0]                ptr_addr,
    output logic                       wb_valid,
    output logic [2:0]                 wb_areg,
    output logic [31:0]                wb_value,
    output logic                       busy
);
    import eag_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // sign extension of the displacement fields
    logic [31:0] bdisp_ext;
    logic [31:0] odisp_ext;
    logic [31:0] d8_ext;
    logic [31:0] wdisp_ext;
    eag_ext u_bdisp (.raw(base_disp), .dsz(base_disp_size), .value(bdisp_ext)); // RULE8
    eag_ext u_odisp (.raw(outer_disp), .dsz(outer_disp_size), .value(odisp_ext)); // RULE9
    eag_ext u_d8 (.raw(ext_word), .dsz(`EAG_DSZ_BYTE), .value(d8_ext)); // RULE5
    eag_ext u_wdisp (.raw(ext_word), .dsz(`EAG_DSZ_WORD), .value(wdisp_ext)); // RULE5

    ////////////////////////////////////////////////////////////////////////////
    // operand size and index scaling
    logic [3:0]  size_bytes;
    logic [5:0]  width_bits;
    logic        size_bad;
    logic [31:0] idx_raw;
    logic [31:0] idx_scaled;
    logic [31:0] step;

    always_comb begin
        size_bad   = 1'b0;
        width_bits = 6'h00;
        unique case (op_type)
            EAG_OP_BYTE:         size_bytes = 4'h1; // RULE17
            EAG_OP_WORD:         size_bytes = 4'h2; // RULE17
            EAG_OP_LONG:         size_bytes = 4'h4; // RULE17
            EAG_OP_QUAD:         size_bytes = 4'h8; // RULE18
            EAG_OP_BCD_PACKED:   size_bytes = 4'h1; // RULE2
            EAG_OP_BCD_UNPACKED: size_bytes = 4'h1; // RULE2
            EAG_OP_BITFIELD: begin
                // a field spans up to five bytes from its base
                size_bytes = 4'h5;
                width_bits = bf_width; // RULE1
                size_bad   = (bf_width < `EAG_BF_MIN) || (bf_width > `EAG_BF_MAX); // RULE1
            end
            default: begin
                size_bytes = 4'h1;
                size_bad   = 1'b1;
            end
        endcase
        // byte access through the stack pointer keeps it word aligned
        if ((size_bytes == 4'h1) && (addr_reg_sel == `EAG_SP_SEL))
            step = 32'h0000_0002;
        else
            step = {28'h0000000, size_bytes}; // RULE19
        idx_raw = index_long ? index_rdata : {{16{index_rdata[15]}}, index_rdata[15:0]}; // RULE6
        if (index_suppress)
            idx_scaled = 32'h0000_0000;
        else
            idx_scaled = idx_raw << index_scale; // RULE7
    end

    ////////////////////////////////////////////////////////////////////////////
    // address sequencing
    typedef enum {S_IDLE, S_FETCH, S_ACCESS} state_type;
    state_type   state_reg, state_next;
    logic [31:0] ea_reg, ea_next;
    logic [31:0] imm_reg, imm_next;
    logic        valid_reg, valid_next;
    logic        is_imm_reg, is_imm_next;
    logic        is_reg_reg, is_reg_next;
    logic        rta_reg, rta_next;
    logic [2:0]  rnum_reg, rnum_next;
    logic [3:0]  bytes_reg, bytes_next;
    logic [5:0]  fbits_reg, fbits_next;
    logic        bad_reg, bad_next;
    logic        preq_reg, preq_next;
    logic [31:0] paddr_reg, paddr_next;
    logic        postidx_reg, postidx_next;
    logic [31:0] idx_reg, idx_next;
    logic [31:0] odisp_reg, odisp_next;
    logic        busy_reg, busy_next;
    logic        wbp_reg, wbp_next;
    logic        wbv_reg, wbv_next;
    logic [2:0]  wba_reg, wba_next;
    logic [31:0] wbd_reg, wbd_next;
    logic [31:0] base;
    logic [31:0] inter;

    always_comb begin
        state_next   = state_reg;
        ea_next      = ea_reg;
        imm_next     = imm_reg;
        valid_next   = 1'b0;
        is_imm_next  = is_imm_reg;
        is_reg_next  = is_reg_reg;
        rta_next     = rta_reg;
        rnum_next    = rnum_reg;
        bytes_next   = bytes_reg;
        fbits_next   = fbits_reg;
        bad_next     = bad_reg;
        preq_next    = preq_reg;
        paddr_next   = paddr_reg;
        postidx_next = postidx_reg;
        idx_next     = idx_reg;
        odisp_next   = odisp_reg;
        wbp_next     = wbp_reg;
        wbv_next     = 1'b0;
        wba_next     = wba_reg;
        wbd_next     = wbd_reg;
        base         = base_suppress ? 32'h0000_0000 : reg_rdata;
        inter        = 32'h0000_0000;
        unique case (state_reg)
            S_IDLE: begin
                if (start) begin
                    valid_next  = 1'b1;
                    is_imm_next = 1'b0;
                    is_reg_next = 1'b0;
                    rta_next    = 1'b1;
                    rnum_next   = addr_reg_sel; // RULE16
                    bytes_next  = size_bytes;
                    fbits_next  = width_bits;
                    bad_next    = size_bad;
                    wbp_next    = 1'b0;
                    wba_next    = addr_reg_sel;
                    unique case (mode) // RULE3
                        EAG_DREG_DIRECT: begin
                            is_reg_next = 1'b1; // RULE16
                            rta_next    = 1'b0;
                            rnum_next   = data_reg_sel;
                        end
                        EAG_AREG_DIRECT: begin
                            is_reg_next = 1'b1; // RULE16
                            // byte access to an address register is not allowed
                            bad_next    = size_bad || (size_bytes == 4'h1);
                        end
                        EAG_AREG_IND: ea_next = reg_rdata; // RULE4
                        EAG_AREG_POSTINC: begin
                            ea_next  = reg_rdata; // RULE4
                            wbp_next = 1'b1;
                            wbd_next = reg_rdata + step; // RULE19
                        end
                        EAG_AREG_PREDEC: begin
                            ea_next  = reg_rdata - step; // RULE19
                            wbp_next = 1'b1;
                            wbd_next = reg_rdata - step; // RULE4
                        end
                        EAG_AREG_DISP: ea_next = reg_rdata + wdisp_ext; // RULE5
                        EAG_AREG_IDX8: ea_next = reg_rdata + d8_ext + idx_scaled; // RULE13
                        EAG_AREG_IDXBD: ea_next = base + bdisp_ext + idx_scaled; // RULE8
                        EAG_PC_DISP: ea_next = pc_value + wdisp_ext; // RULE12
                        EAG_PC_IDX8: ea_next = pc_value + d8_ext + idx_scaled; // RULE13
                        EAG_PC_IDXBD: ea_next = (base_suppress ? 32'h0000_0000 : pc_value)
                                                + bdisp_ext + idx_scaled; // RULE12
                        EAG_MEM_POSTIDX, EAG_MEM_PREIDX,
                        EAG_PC_MEM_POSTIDX, EAG_PC_MEM_PREIDX: begin
                            if ((mode == EAG_PC_MEM_POSTIDX) || (mode == EAG_PC_MEM_PREIDX))
                                inter = (base_suppress ? 32'h0000_0000 : pc_value) + bdisp_ext;
                            else
                                inter = base + bdisp_ext; // RULE8
                            postidx_next = (mode == EAG_MEM_POSTIDX)
                                        || (mode == EAG_PC_MEM_POSTIDX); // RULE10
                            if (!postidx_next)
                                inter = inter + idx_scaled; // RULE10
                            idx_next   = idx_scaled;
                            odisp_next = odisp_ext;
                            paddr_next = inter;
                            preq_next  = 1'b1; // RULE11
                            valid_next = 1'b0;
                            state_next = S_FETCH;
                        end
                        EAG_ABS_SHORT: ea_next = wdisp_ext; // RULE15
                        EAG_ABS_LONG: ea_next = ext_word; // RULE15
                        EAG_IMMEDIATE: begin
                            is_imm_next = 1'b1;
                            unique case (size_bytes) // RULE14
                                4'h1:    imm_next = {24'h000000, ext_word[7:0]};
                                4'h2:    imm_next = {16'h0000, ext_word[15:0]};
                                default: imm_next = ext_word;
                            endcase
                        end
                    endcase
                    if (wbp_next && valid_next)
                        state_next = S_ACCESS;
                end
            end
            S_FETCH: begin
                if (ptr_ack) begin
                    preq_next  = 1'b0;
                    // the fetched long word becomes the new base, outer term last
                    ea_next    = ptr_data + (postidx_reg ? idx_reg : 32'h0000_0000)
                                 + odisp_reg; // RULE9
                    valid_next = 1'b1;
                    state_next = S_IDLE;
                end
            end
            S_ACCESS: begin
                if (access_done) begin
                    wbv_next   = 1'b1; // RULE19
                    wbp_next   = 1'b0;
                    state_next = S_IDLE;
                end
            end
        endcase
        busy_next = (state_next != S_IDLE);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg   <= S_IDLE;
            ea_reg      <= 32'h0000_0000;
            imm_reg     <= 32'h0000_0000;
            valid_reg   <= 1'b0;
            is_imm_reg  <= 1'b0;
            is_reg_reg  <= 1'b0;
            rta_reg     <= 1'b0;
            rnum_reg    <= 3'h0;
            bytes_reg   <= 4'h0;
            fbits_reg   <= 6'h00;
            bad_reg     <= 1'b0;
            preq_reg    <= 1'b0;
            paddr_reg   <= 32'h0000_0000;
            postidx_reg <= 1'b0;
            idx_reg     <= 32'h0000_0000;
            odisp_reg   <= 32'h0000_0000;
            busy_reg    <= 1'b0;
            wbp_reg     <= 1'b0;
            wbv_reg     <= 1'b0;
            wba_reg     <= 3'h0;
            wbd_reg     <= 32'h0000_0000;
        end else begin
            state_reg   <= state_next;
            ea_reg      <= ea_next;
            imm_reg     <= imm_next;
            valid_reg   <= valid_next;
            is_imm_reg  <= is_imm_next;
            is_reg_reg  <= is_reg_next;
            rta_reg     <= rta_next;
            rnum_reg    <= rnum_next;
            bytes_reg   <= bytes_next;
            fbits_reg   <= fbits_next;
            bad_reg     <= bad_next;
            preq_reg    <= preq_next;
            paddr_reg   <= paddr_next;
            postidx_reg <= postidx_next;
            idx_reg     <= idx_next;
            odisp_reg   <= odisp_next;
            busy_reg    <= busy_next;
            wbp_reg     <= wbp_next;
            wbv_reg     <= wbv_next;
            wba_reg     <= wba_next;
            wbd_reg     <= wbd_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign ea          = ea_reg;
    assign imm_value   = imm_reg;
    assign ea_valid    = valid_reg;
    assign is_imm      = is_imm_reg;
    assign is_reg      = is_reg_reg;
    assign reg_is_addr = rta_reg;
    assign reg_num     = rnum_reg;
    assign op_bytes    = bytes_reg;
    assign field_bits  = fbits_reg;
    assign bad_operand = bad_reg;
    assign ptr_req     = preq_reg;
    assign ptr_addr    = paddr_reg;
    assign wb_valid    = wbv_reg;
    assign wb_areg     = wba_reg;
    assign wb_value    = wbd_reg;
    assign busy        = busy_reg;
endmodule : eag_top
`default_nettype wire

// >>> test/eag_checker.sv
`timescale 1ns/1ps
`default_nettype none
module eag_checker (
    input wire logic                    clk,
    input wire logic                    rst_n,
    input wire logic                    start,
    input wire eag_pkg::eag_mode_type   mode,
    input wire eag_pkg::eag_optype_type op_type,
    input wire logic [5:0]              bf_width,
    input wire logic                    ptr_ack,
    input wire logic                    access_done,
    input wire logic [31:0]             ea,
    input wire logic                    ea_valid,
    input wire logic [3:0]              op_bytes,
    input wire logic [5:0]              field_bits,
    input wire logic                    bad_operand,
    input wire logic                    ptr_req,
    input wire logic [31:0]             ptr_addr,
    input wire logic                    wb_valid,
    input wire logic [2:0]              wb_areg,
    input wire logic [31:0]             wb_value,
    input wire logic                    busy
);
    import eag_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic        mem_mode;
    logic        bf_ok;
    logic [31:0] step;
    assign mem_mode = mode inside {EAG_MEM_POSTIDX, EAG_MEM_PREIDX,
                                   EAG_PC_MEM_POSTIDX, EAG_PC_MEM_PREIDX};
    assign bf_ok = bf_width != 6'h00 && bf_width <= 6'h20;
    assign step = (op_bytes == 4'h1 && wb_areg == 3'h7) ? 32'h2 : 32'(op_bytes);
    sequence s_take;
        start && !busy;
    endsequence
    sequence s_fetch;
        ptr_req && ptr_ack;
    endsequence
    chk_calc_answer: assert property (s_take ##0 !mem_mode |=> ea_valid)
        else $error("ea_valid late");
    chk_mem_request: assert property (s_take ##0 mem_mode |=> ptr_req && busy && !ea_valid)
        else $error("no ptr_req");
    chk_ptr_hold: assert property (ptr_req && !ptr_ack |=> ptr_req && $stable(ptr_addr))
        else $error("ptr_req unstable");
    chk_ack_answer: assert property (s_fetch |=> ea_valid && !ptr_req)
        else $error("no answer after ack");
    chk_valid_pulse: assert property (ea_valid && !start |=> !ea_valid)
        else $error("ea_valid held");
    chk_wb_pulse: assert property (wb_valid |=> !wb_valid)
        else $error("wb_valid held");
    chk_done_wb: assert property (busy && access_done && !ptr_req |=> wb_valid && !busy)
        else $error("no write back");
    chk_wb_step: assert property (wb_valid |-> wb_value == ea || wb_value == ea + step)
        else $error("wb_value step");
    chk_bf_range: assert property (s_take ##0 op_type == EAG_OP_BITFIELD && !mem_mode
        |=> bad_operand == !$past(bf_ok))
        else $error("width flag");
    chk_bf_width: assert property (s_take ##0 op_type == EAG_OP_BITFIELD && bf_ok
        |=> field_bits == $past(bf_width))
        else $error("field_bits");
    chk_idle_quiet: assert property (!busy |-> !ptr_req)
        else $error("idle ptr_req");
endmodule : eag_checker
bind eag_top eag_checker chk_i (.*);
`default_nettype wire

// >>> test/eag_partner.sv
`timescale 1ns/1ps
`default_nettype none
module eag_partner (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [3:0]  dly,
    input  wire logic [31:0] ptr_value,
    input  wire logic        ptr_req,
    input  wire logic        ea_valid,
    input  wire logic        busy,
    output logic             ptr_ack,
    output logic [31:0]      ptr_data,
    output logic             access_done
);
    logic [3:0] cnt_ptr;
    logic [3:0] cnt_acc;
    logic       acc_wait;
    always @(posedge clk) begin
        if (!rst_n) begin
            ptr_ack <= 1'b0;
            ptr_data <= 32'h0;
            access_done <= 1'b0;
            cnt_ptr <= 4'h0;
            cnt_acc <= 4'h0;
            acc_wait <= 1'b0;
        end else begin
            ptr_ack <= 1'b0;
            access_done <= 1'b0;
            ptr_data <= ~ptr_data;
            if (ptr_req && !ptr_ack) begin
                cnt_ptr <= cnt_ptr + 4'h1;
                if (cnt_ptr >= dly) begin
                    ptr_ack <= 1'b1;
                    ptr_data <= ptr_value;
                    cnt_ptr <= 4'h0;
                end
            end
            if (ea_valid && busy) begin
                acc_wait <= 1'b1;
            end
            if (acc_wait) begin
                cnt_acc <= cnt_acc + 4'h1;
                if (cnt_acc >= dly) begin
                    access_done <= 1'b1;
                    acc_wait <= 1'b0;
                    cnt_acc <= 4'h0;
                end
            end
        end
    end
endmodule : eag_partner
`default_nettype wire

// >>> test/effective_address_generator_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module effective_address_generator_tb_top;
    import eag_pkg::*;
    localparam logic [31:0] RB = 32'h0001_0000;
    localparam logic [31:0] PB = 32'h0002_0000;
    localparam logic [31:0] PT = 32'h0040_0000;
    localparam logic [31:0] IL = 32'h0003_fff0;
    localparam logic [31:0] IW = 32'hffff_fff0;
    logic clk = 0, rst_n = 0, start = 0, index_long = 0, index_suppress = 0, base_suppress = 0;
    eag_mode_type mode = EAG_DREG_DIRECT;
    eag_optype_type op_type = EAG_OP_LONG;
    logic [5:0] bf_width = 6'h01;
    logic [2:0] data_reg_sel = 0, addr_reg_sel = 0;
    logic [1:0] index_scale = 0, base_disp_size = 0, outer_disp_size = 0;
    logic [31:0] base_disp = 0, outer_disp = 0, ext_word = 0;
    logic [3:0] dly = 0;
    logic [31:0] ea, imm_value, ptr_addr, wb_value, ptr_data, wb_seen, pa_seen;
    logic ea_valid, is_imm, is_reg, reg_is_addr, bad_operand, ptr_req, wb_valid, busy;
    logic ptr_ack, access_done;
    logic [2:0] reg_num, wb_areg, wa_seen;
    logic [3:0] op_bytes;
    logic [5:0] field_bits;
    int n_fail = 0, num_checks = 0, cyc = 0;
    eag_top uut (.*, .index_reg_sel(4'h9), .pc_value(PB), .reg_rdata(RB), .index_rdata(IL));
    eag_partner far_i (.*, .ptr_value(PT));
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            test_done;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        if (n_fail == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : test_done
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : check
    task automatic go(input eag_mode_type m, input eag_optype_type t);
        logic ok;
        @(posedge clk);
        mode <= m;
        op_type <= t;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        ok = 0;
        for (int k = 0; k < 20 && !ok; k++) begin
            @(negedge clk);
            if (ptr_req === 1'b1) pa_seen = ptr_addr;
            ok = (ea_valid === 1'b1);
        end
        check("ea_valid", 32'h1, 32'(ok));
        for (int k = 0; k < 20 && busy === 1'b1; k++) begin
            @(negedge clk);
            wb_seen = wb_value;
            wa_seen = wb_areg;
        end
    endtask : go
    task automatic incdec(input logic [2:0] sel, input eag_mode_type m, input eag_optype_type t,
                          input logic [31:0] e_ea, input logic [31:0] e_wb);
        @(posedge clk);
        addr_reg_sel <= sel;
        go(m, t);
        check("ea", e_ea, ea);
        check("wb_value", e_wb, wb_seen);
        check("wb_areg", 32'(sel), 32'(wa_seen));
    endtask : incdec
    ////////////////////////////////////////////////////////////////////////
    task automatic t_direct;
        @(posedge clk);
        data_reg_sel <= 3'h5;
        addr_reg_sel <= 3'h3;
        go(EAG_DREG_DIRECT, EAG_OP_LONG);
        check("reg", 32'h15, 32'({is_reg, reg_is_addr, reg_num}));
        go(EAG_AREG_DIRECT, EAG_OP_WORD);
        check("reg", 32'h1b, 32'({is_reg, reg_is_addr, reg_num}));
        check("bad_operand", 32'h0, 32'(bad_operand));
        go(EAG_AREG_DIRECT, EAG_OP_BYTE);
        check("bad_operand", 32'h1, 32'(bad_operand));
    endtask : t_direct
    task automatic t_incdec;
        incdec(3'h2, EAG_AREG_POSTINC, EAG_OP_LONG, RB, RB + 32'h4);
        incdec(3'h1, EAG_AREG_POSTINC, EAG_OP_BYTE, RB, RB + 32'h1);
        @(posedge clk);
        dly <= 4'h3;
        incdec(3'h3, EAG_AREG_PREDEC, EAG_OP_WORD, RB - 32'h2, RB - 32'h2);
        incdec(3'h7, EAG_AREG_PREDEC, EAG_OP_BYTE, RB - 32'h2, RB - 32'h2);
        incdec(3'h7, EAG_AREG_POSTINC, EAG_OP_BYTE, RB, RB + 32'h2);
    endtask : t_incdec
    task automatic t_index;
        logic [31:0] x;
        @(posedge clk);
        ext_word <= 32'h0000_fffe;
        go(EAG_AREG_DISP, EAG_OP_LONG);
        check("ea", RB - 32'h2, ea);
        go(EAG_PC_DISP, EAG_OP_LONG);
        check("ea", PB - 32'h2, ea);
        for (int s = 0; s < 4; s++) for (int l = 0; l < 2; l++) begin
            x = (l != 0 ? IL : IW) << s;
            @(posedge clk);
            ext_word <= 32'h0000_00fc;
            index_scale <= 2'(s);
            index_long <= 1'(l);
            go(EAG_AREG_IDX8, EAG_OP_LONG);
            check("ea", RB - 32'h4 + x, ea);
            go(EAG_PC_IDX8, EAG_OP_LONG);
            check("ea", PB - 32'h4 + x, ea);
        end
        @(posedge clk);
        base_disp <= 32'h0000_8000;
        base_disp_size <= 2'h2;
        index_scale <= 2'h1;
        go(EAG_AREG_IDXBD, EAG_OP_LONG);
        check("ea", RB - 32'h8000 + (IL << 1), ea);
        @(posedge clk);
        base_suppress <= 1'b1;
        index_suppress <= 1'b1;
        go(EAG_PC_IDXBD, EAG_OP_LONG);
        check("ea", 32'hffff_8000, ea);
    endtask : t_index
    task automatic t_mem;
        @(posedge clk);
        base_suppress <= 1'b0;
        index_suppress <= 1'b0;
        base_disp <= 32'h0000_0100;
        base_disp_size <= 2'h3;
        outer_disp <= 32'h0000_0010;
        outer_disp_size <= 2'h2;
        index_scale <= 2'h2;
        dly <= 4'h0;
        go(EAG_MEM_POSTIDX, EAG_OP_LONG);
        check("ptr_addr", RB + 32'h100, pa_seen);
        check("ea", PT + (IL << 2) + 32'h10, ea);
        go(EAG_MEM_PREIDX, EAG_OP_LONG);
        check("ptr_addr", RB + 32'h100 + (IL << 2), pa_seen);
        check("ea", PT + 32'h10, ea);
        @(posedge clk);
        dly <= 4'h3;
        base_suppress <= 1'b1;
        outer_disp <= 32'h0100_0000;
        outer_disp_size <= 2'h3;
        go(EAG_PC_MEM_PREIDX, EAG_OP_LONG);
        check("ptr_addr", 32'h100 + (IL << 2), pa_seen);
        check("ea", PT + 32'h0100_0000, ea);
        go(EAG_PC_MEM_POSTIDX, EAG_OP_LONG);
        check("ea", PT + (IL << 2) + 32'h0100_0000, ea);
    endtask : t_mem
    task automatic t_absimm;
        @(posedge clk);
        ext_word <= 32'h1234_80a5;
        go(EAG_ABS_SHORT, EAG_OP_LONG);
        check("ea", 32'hffff_80a5, ea);
        go(EAG_ABS_LONG, EAG_OP_LONG);
        check("ea", 32'h1234_80a5, ea);
        go(EAG_IMMEDIATE, EAG_OP_BYTE);
        check("imm_value", 32'h0000_00a5, imm_value);
        check("is_imm", 32'h1, 32'(is_imm));
        go(EAG_IMMEDIATE, EAG_OP_WORD);
        check("imm_value", 32'h0000_80a5, imm_value);
        go(EAG_IMMEDIATE, EAG_OP_LONG);
        check("imm_value", 32'h1234_80a5, imm_value);
    endtask : t_absimm
    task automatic t_types;
        eag_optype_type tl [4] = '{EAG_OP_BYTE, EAG_OP_WORD, EAG_OP_LONG, EAG_OP_QUAD};
        logic [5:0] wl [4] = '{6'h00, 6'h01, 6'h20, 6'h21};
        for (int i = 0; i < 4; i++) begin
            go(EAG_DREG_DIRECT, tl[i]);
            check("op_bytes", 32'h1 << i, 32'(op_bytes));
            @(posedge clk);
            bf_width <= wl[i];
            go(EAG_DREG_DIRECT, EAG_OP_BITFIELD);
            check("bad_operand", 32'(i == 0 || i == 3), 32'(bad_operand));
            if (i == 1 || i == 2) check("field_bits", 32'(wl[i]), 32'(field_bits));
        end
        go(EAG_DREG_DIRECT, EAG_OP_BCD_PACKED);
        check("bad_operand", 32'h0, 32'(bad_operand));
        go(EAG_DREG_DIRECT, EAG_OP_BCD_UNPACKED);
        check("bad_operand", 32'h0, 32'(bad_operand));
    endtask : t_types
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        check("idle", 32'h0, 32'({busy, ea_valid, ptr_req, wb_valid}));
        t_direct;
        t_incdec;
        t_index;
        t_mem;
        t_absimm;
        t_types;
        for (int i = 0; i < 18; i++) go(eag_mode_type'(i), EAG_OP_LONG);
        test_done;
    end
endmodule : effective_address_generator_tb_top
`default_nettype wire
